// ### design/aiam_monitor.sv
// aiam_monitor: per-channel alarm, max/min log, average and fault flags for converted samples
// assumes samples and register strobes come from logic on clk, so no synchronisers
//
// Implementation choices: the register offsets and the plain strobed port.
`timescale 1ns/1ns
module aiam_monitor
    import aiam_pkg::*;
(
    // clock and reset
    input  wire logic         clk,
    input  wire logic         nrst,
    // register port
    input  wire aiam_bus_t    bus,
    output logic [BW-1:0]     busRdata,
    // converter front end
    input  wire aiam_sample_t smp,
    // digital outputs and status
    output logic [NDO-1:0]    dout,
    output logic [NCH-1:0]    hiAlarm,
    output logic [NCH-1:0]    loAlarm,
    output logic [NCH-1:0]    burnout,
    output logic [NCH-1:0]    overRange
);
    aiam_state_t s;
    aiam_state_t n;

    function automatic logic active(input aiam_mode_t m);
        return (m == ALM_LATCH) || (m == ALM_MOMENT);
    endfunction : active

    function automatic aiam_mode_t toMode(input logic [1:0] v);
        // the unused code is treated as disabled so no alarm can drive an output from it
        return (v == ALM_LATCH || v == ALM_MOMENT) ? aiam_mode_t'(v) : ALM_OFF;
    endfunction : toMode

    // combinational divide: area traded for an average ready in the sample's cycle
    function automatic logic [DW-1:0] mean(input logic [NCH-1:0][DW-1:0] v,
                                           input logic [NCH-1:0]         en);
        logic [DW+CW:0] sum;
        logic [CW:0]    k;
        sum = '0;
        k   = '0;
        for (int i = 0; i < NCH; i++) begin
            if (en[i]) begin
                sum = sum + (DW+CW+1)'(v[i]);
                k   = (CW+1)'(k + 1'b1);
            end
        end
        return (k == '0) ? '0 : DW'(sum / k);
    endfunction : mean

    logic [NCH-1:0] clrHi;
    logic [NCH-1:0] clrLo;
    logic [NCH-1:0] mmRst;
    logic           chWin;
    logic [CW-1:0]  chIdx;
    logic [2:0]     fld;
    logic           hiCond;
    logic           loCond;

    assign chWin = (bus.addr[AW-1:AW-2] == CH_SEL);
    assign chIdx = bus.addr[5:3];
    assign fld   = bus.addr[2:0];
    assign clrHi = (bus.wr && bus.addr == OFF_CLRLATCH) ? bus.wdata[NCH-1:0] : '0;
    assign clrLo = (bus.wr && bus.addr == OFF_CLRLATCH) ?
                   bus.wdata[CLR_LO_POS +: NCH] : '0;
    assign mmRst = (bus.wr && bus.addr == OFF_MMRESET) ? bus.wdata[NCH-1:0] : '0;
    assign hiCond = smp.value > s.hiLim[smp.chan];
    assign loCond = smp.value < s.loLim[smp.chan];

    always_comb begin
        n = s;
        n.rdata = '0;
        // register writes
        if (bus.wr) begin
            if (chWin) begin
                case (fld)
                    F_HILIM: n.hiLim[chIdx] = bus.wdata[DW-1:0];
                    F_LOLIM: n.loLim[chIdx] = bus.wdata[DW-1:0];
                    F_MODE: begin
                        n.hiMode[chIdx] = toMode(bus.wdata[1:0]);
                        n.loMode[chIdx] = toMode(bus.wdata[MODE_LO_POS +: 2]);
                    end
                    F_MAP: begin
                        n.hiMap[chIdx] = bus.wdata[DOW-1:0];
                        n.loMap[chIdx] = bus.wdata[MAP_LO_POS +: DOW];
                    end
                    default: ;
                endcase
            end else begin
                case (bus.addr)
                    OFF_AVGEN:   n.avgEn   = bus.wdata[NCH-1:0];
                    OFF_RANGELO: n.rangeLo = bus.wdata[DW-1:0];
                    OFF_RANGEHI: n.rangeHi = bus.wdata[DW-1:0];
                    OFF_BURNSUP: n.burnSup = bus.wdata[NCH-1:0];
                    default: ;
                endcase
            end
        end
        // clear and log reset commands land first so a same-cycle sample wins
        n.hiStat = n.hiStat & ~clrHi;
        n.loStat = n.loStat & ~clrLo;
        for (int c = 0; c < NCH; c++) begin
            if (mmRst[c]) begin
                n.maxV[c] = MAX_INIT;
                n.minV[c] = MIN_INIT;
            end
        end
        // sample processing, once per converted sample
        if (smp.valid) begin
            n.lastV[smp.chan] = smp.value;
            n.burn[smp.chan]  = smp.openSensor && s.burnSup[smp.chan];
            n.ovr[smp.chan]   = (smp.value > s.rangeHi) ||
                                (smp.value < s.rangeLo);
            case (s.hiMode[smp.chan])
                ALM_LATCH: begin
                    if (hiCond) begin
                        n.hiStat[smp.chan] = 1'b1;
                    end
                end
                ALM_MOMENT: n.hiStat[smp.chan] = hiCond;
                default: ;
            endcase
            case (s.loMode[smp.chan])
                ALM_LATCH: begin
                    if (loCond) begin
                        n.loStat[smp.chan] = 1'b1;
                    end
                end
                ALM_MOMENT: n.loStat[smp.chan] = loCond;
                default: ;
            endcase
            if (smp.value > n.maxV[smp.chan] || mmRst[smp.chan]) begin
                n.maxV[smp.chan] = smp.value;
            end
            if (smp.value < n.minV[smp.chan] || mmRst[smp.chan]) begin
                n.minV[smp.chan] = smp.value;
            end
            n.avg = mean(n.lastV, n.avgEn);
        end
        // output mapping: several alarms on one output are or-ed together
        n.dout = '0;
        for (int d = 0; d < NDO; d++) begin
            for (int c = 0; c < NCH; c++) begin
                if ((active(n.hiMode[c]) && n.hiStat[c] && n.hiMap[c] == DOW'(d)) ||
                    (active(n.loMode[c]) && n.loStat[c] && n.loMap[c] == DOW'(d))) begin
                    n.dout[d] = 1'b1;
                end
            end
        end
        // read data, valid only in the cycle after the strobe
        if (bus.rd) begin
            if (chWin) begin
                case (fld)
                    F_HILIM: n.rdata = BW'(s.hiLim[chIdx]);
                    F_LOLIM: n.rdata = BW'(s.loLim[chIdx]);
                    F_MODE:  n.rdata = BW'({s.loMode[chIdx], s.hiMode[chIdx]});
                    F_MAP:   n.rdata = BW'({1'b0, s.loMap[chIdx], 1'b0, s.hiMap[chIdx]});
                    F_MAX:   n.rdata = BW'(s.maxV[chIdx]);
                    F_MIN:   n.rdata = BW'(s.minV[chIdx]);
                    F_LAST:  n.rdata = BW'(s.lastV[chIdx]);
                    default: n.rdata = '0;
                endcase
            end else begin
                case (bus.addr)
                    OFF_AVGEN:   n.rdata = BW'(s.avgEn);
                    OFF_AVG:     n.rdata = BW'(s.avg);
                    OFF_ALMSTAT: n.rdata = BW'({s.loStat, s.hiStat});
                    OFF_FAULT:   n.rdata = BW'({s.ovr, s.burn});
                    OFF_RANGELO: n.rdata = BW'(s.rangeLo);
                    OFF_RANGEHI: n.rdata = BW'(s.rangeHi);
                    OFF_BURNSUP: n.rdata = BW'(s.burnSup);
                    OFF_DOUT:    n.rdata = BW'(s.dout);
                    default:     n.rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s         <= '0;
            s.hiLim   <= {NCH{HILIM_RST}};
            s.loLim   <= {NCH{LOLIM_RST}};
            s.maxV    <= {NCH{MAX_INIT}};
            s.minV    <= {NCH{MIN_INIT}};
            s.rangeLo <= RANGELO_RST;
            s.rangeHi <= RANGEHI_RST;
        end else begin
            s <= n;
        end
    end

    assign busRdata  = s.rdata;
    assign dout      = s.dout;
    assign hiAlarm   = s.hiStat;
    assign loAlarm   = s.loStat;
    assign burnout   = s.burn;
    assign overRange = s.ovr;

    // checks tied to one channel use a fixed index; the logic is identical for every channel
    a_latch_hold: assert property (@(posedge clk) disable iff (!nrst)
        s.hiStat[0] && s.hiMode[0] == ALM_LATCH && !bus.wr |=> s.hiStat[0])
        else $error("latched high alarm dropped without clear");
    a_low_latch: assert property (@(posedge clk) disable iff (!nrst)
        smp.valid && s.loMode[smp.chan] == ALM_LATCH &&
        smp.value < s.loLim[smp.chan] |=> s.loStat[$past(smp.chan)])
        else $error("low alarm not latched below limit");
    a_moment_follow: assert property (@(posedge clk) disable iff (!nrst)
        smp.valid && smp.chan == '0 && s.hiMode[0] == ALM_MOMENT && !bus.wr
        |=> s.hiStat[0] == ($past(smp.value) > $past(s.hiLim[0])))
        else $error("momentary alarm does not follow condition");
    a_disabled_hold: assert property (@(posedge clk) disable iff (!nrst)
        s.hiMode[0] == ALM_OFF && !bus.wr |=> $stable(s.hiStat[0]))
        else $error("disabled alarm status changed");
    a_output_map: assert property (@(posedge clk) disable iff (!nrst)
        s.hiStat[0] && active(s.hiMode[0]) |-> s.dout[s.hiMap[0]])
        else $error("mapped output not driven by active alarm");
    a_max_track: assert property (@(posedge clk) disable iff (!nrst)
        smp.valid && smp.chan == '0 |=> s.maxV[0] >= $past(smp.value))
        else $error("maximum below a seen sample");
    a_min_track: assert property (@(posedge clk) disable iff (!nrst)
        smp.valid && smp.chan == '0 |=> s.minV[0] <= $past(smp.value))
        else $error("minimum above a seen sample");
    a_avg_single: assert property (@(posedge clk) disable iff (!nrst)
        smp.valid && s.avgEn == (NCH'(1) << smp.chan) && !bus.wr
        |=> s.avg == $past(smp.value))
        else $error("average of one channel differs from it");
    a_range_flag: assert property (@(posedge clk) disable iff (!nrst)
        smp.valid && (smp.value > s.rangeHi || smp.value < s.rangeLo)
        |=> s.ovr[$past(smp.chan)])
        else $error("over-range not flagged");
    a_burn_flag: assert property (@(posedge clk) disable iff (!nrst)
        smp.valid && smp.openSensor && s.burnSup[smp.chan] |=> s.burn[$past(smp.chan)])
        else $error("burnout not flagged");
    // the other alarm half, the host commands and the cycles without a sample
    a_low_moment: assert property (@(posedge clk) disable iff (!nrst)
        smp.valid && smp.chan == '0 && s.loMode[0] == ALM_MOMENT
        |=> s.loStat[0] == ($past(smp.value) < $past(s.loLim[0])))
        else $error("momentary low alarm does not follow condition");
    a_high_latch: assert property (@(posedge clk) disable iff (!nrst)
        smp.valid && s.hiMode[smp.chan] == ALM_LATCH &&
        smp.value > s.hiLim[smp.chan] |=> s.hiStat[$past(smp.chan)])
        else $error("high alarm not latched above limit");
    a_low_hold: assert property (@(posedge clk) disable iff (!nrst)
        s.loStat[1] && s.loMode[1] == ALM_LATCH && !bus.wr |=> s.loStat[1])
        else $error("latched low alarm dropped without clear");
    a_clear_drop: assert property (@(posedge clk) disable iff (!nrst)
        bus.wr && bus.addr == OFF_CLRLATCH && bus.wdata[0] && !smp.valid |=> !s.hiStat[0])
        else $error("clear command left high alarm set");
    a_low_output: assert property (@(posedge clk) disable iff (!nrst)
        s.loStat[0] && active(s.loMode[0]) |-> s.dout[s.loMap[0]])
        else $error("mapped output not driven by low alarm");
    a_output_quiet: assert property (@(posedge clk) disable iff (!nrst)
        s.hiStat == '0 && s.loStat == '0 |-> s.dout == '0)
        else $error("output driven with no alarm set");
    a_low_disabled: assert property (@(posedge clk) disable iff (!nrst)
        s.loMode[0] == ALM_OFF && !bus.wr |=> $stable(s.loStat[0]))
        else $error("disabled low alarm status changed");
    a_max_reset: assert property (@(posedge clk) disable iff (!nrst)
        bus.wr && bus.addr == OFF_MMRESET && bus.wdata[2] && !smp.valid
        |=> s.maxV[2] == MAX_INIT)
        else $error("maximum not reinitialised");
    a_min_reset: assert property (@(posedge clk) disable iff (!nrst)
        bus.wr && bus.addr == OFF_MMRESET && bus.wdata[2] && !smp.valid
        |=> s.minV[2] == MIN_INIT)
        else $error("minimum not reinitialised");
    a_last_store: assert property (@(posedge clk) disable iff (!nrst)
        smp.valid |=> s.lastV[$past(smp.chan)] == $past(smp.value))
        else $error("sample not stored for its channel");
    a_no_sample: assert property (@(posedge clk) disable iff (!nrst)
        !smp.valid |=> $stable(s.lastV) && $stable(s.burn) && $stable(s.ovr) && $stable(s.avg))
        else $error("results moved without a sample");
    a_burn_off: assert property (@(posedge clk) disable iff (!nrst)
        smp.valid && !(smp.openSensor && s.burnSup[smp.chan]) |=> !s.burn[$past(smp.chan)])
        else $error("burnout flagged without cause");
    a_range_in: assert property (@(posedge clk) disable iff (!nrst)
        smp.valid && smp.value <= s.rangeHi && smp.value >= s.rangeLo
        |=> !s.ovr[$past(smp.chan)])
        else $error("over-range flagged inside range");
    a_hilim_write: assert property (@(posedge clk) disable iff (!nrst)
        bus.wr && chWin && fld == F_HILIM |=> s.hiLim[$past(chIdx)] == DW'($past(bus.wdata)))
        else $error("high limit not stored");
    a_lolim_write: assert property (@(posedge clk) disable iff (!nrst)
        bus.wr && chWin && fld == F_LOLIM |=> s.loLim[$past(chIdx)] == DW'($past(bus.wdata)))
        else $error("low limit not stored");
    a_mode_decode: assert property (@(posedge clk) disable iff (!nrst)
        bus.wr && chWin && fld == F_MODE && bus.wdata[1:0] == 2'h3
        |=> s.hiMode[$past(chIdx)] == ALM_OFF)
        else $error("unused mode code not taken as disabled");
    a_map_write: assert property (@(posedge clk) disable iff (!nrst)
        bus.wr && chWin && fld == F_MAP |=> s.hiMap[$past(chIdx)] == DOW'($past(bus.wdata)))
        else $error("output mapping not stored");
    a_avg_none: assert property (@(posedge clk) disable iff (!nrst)
        smp.valid && s.avgEn == '0 && !bus.wr |=> s.avg == '0)
        else $error("average nonzero with no channel enabled");
endmodule : aiam_monitor

// ### pkg/aiam_pkg.sv
// aiam_pkg: constants, register map and carrier types of the analog input alarm monitor
// assumes one clock domain shared with the converter front end and the register master
package aiam_pkg;
    localparam int NCH = 8;
    localparam int CW  = 3;
    localparam int DW  = 16;
    localparam int NDO = 8;
    localparam int DOW = 3;
    localparam int AW  = 8;
    localparam int BW  = 32;

    // global registers, word addresses
    localparam logic [AW-1:0] OFF_AVGEN    = 8'h00;
    localparam logic [AW-1:0] OFF_AVG      = 8'h01;
    localparam logic [AW-1:0] OFF_ALMSTAT  = 8'h02;
    localparam logic [AW-1:0] OFF_CLRLATCH = 8'h03;
    localparam logic [AW-1:0] OFF_MMRESET  = 8'h04;
    localparam logic [AW-1:0] OFF_FAULT    = 8'h05;
    localparam logic [AW-1:0] OFF_RANGELO  = 8'h06;
    localparam logic [AW-1:0] OFF_RANGEHI  = 8'h07;
    localparam logic [AW-1:0] OFF_BURNSUP  = 8'h08;
    localparam logic [AW-1:0] OFF_DOUT     = 8'h09;
    // per-channel block: addr[7:6] selects, addr[5:3] channel, addr[2:0] field
    localparam logic [1:0]    CH_SEL  = 2'h1;
    localparam logic [2:0]    F_HILIM = 3'h0;
    localparam logic [2:0]    F_LOLIM = 3'h1;
    localparam logic [2:0]    F_MODE  = 3'h2;
    localparam logic [2:0]    F_MAP   = 3'h3;
    localparam logic [2:0]    F_MAX   = 3'h4;
    localparam logic [2:0]    F_MIN   = 3'h5;
    localparam logic [2:0]    F_LAST  = 3'h6;
    // field positions inside the mode, map and clear-latch words
    localparam int MODE_LO_POS = 2;
    localparam int MAP_LO_POS  = 4;
    localparam int CLR_LO_POS  = 8;

    localparam logic [DW-1:0] MAX_INIT    = 16'h0000;
    localparam logic [DW-1:0] MIN_INIT    = 16'hffff;
    localparam logic [DW-1:0] HILIM_RST   = 16'hffff;
    localparam logic [DW-1:0] LOLIM_RST   = 16'h0000;
    localparam logic [DW-1:0] RANGELO_RST = 16'h0000;
    localparam logic [DW-1:0] RANGEHI_RST = 16'hffff;

    typedef enum logic [1:0] {
        ALM_OFF    = 2'b00,
        ALM_LATCH  = 2'b01,
        ALM_MOMENT = 2'b10
    } aiam_mode_t;

    typedef struct packed {
        logic          wr;
        logic          rd;
        logic [AW-1:0] addr;
        logic [BW-1:0] wdata;
    } aiam_bus_t;

    typedef struct packed {
        logic          valid;
        logic [CW-1:0] chan;
        logic [DW-1:0] value;
        logic          openSensor;
    } aiam_sample_t;

    typedef struct packed {
        logic [NCH-1:0][DW-1:0]  hiLim;
        logic [NCH-1:0][DW-1:0]  loLim;
        logic [NCH-1:0][DW-1:0]  maxV;
        logic [NCH-1:0][DW-1:0]  minV;
        logic [NCH-1:0][DW-1:0]  lastV;
        aiam_mode_t [NCH-1:0]    hiMode;
        aiam_mode_t [NCH-1:0]    loMode;
        logic [NCH-1:0][DOW-1:0] hiMap;
        logic [NCH-1:0][DOW-1:0] loMap;
        logic [NCH-1:0]          hiStat;
        logic [NCH-1:0]          loStat;
        logic [NCH-1:0]          avgEn;
        logic [NCH-1:0]          burn;
        logic [NCH-1:0]          ovr;
        logic [NCH-1:0]          burnSup;
        logic [DW-1:0]           rangeLo;
        logic [DW-1:0]           rangeHi;
        logic [DW-1:0]           avg;
        logic [NDO-1:0]          dout;
        logic [BW-1:0]           rdata;
    } aiam_state_t;
endpackage : aiam_pkg

// ### tb/aiam_front_model.sv
// aiam_front_model: converter front end stand-in, one strobe per converted sample
// assumes the bench calls send after reset, one call at a time, from clk-edge timing
`timescale 1ns/1ns
module aiam_front_model
    import aiam_pkg::*;
(
    // clock
    input  wire logic   clk,
    // sample stream toward the monitor
    output aiam_sample_t smp
);
    initial smp = '0;

    task automatic send(input logic [CW-1:0] ch, input logic [DW-1:0] v, input logic op);
        @(posedge clk);
        smp <= '{valid: 1'b1, chan: ch, value: v, openSensor: op};
        @(posedge clk);
        // lines are inverted between strobes so a stale code is never mistaken for live data
        smp <= '{valid: 1'b0, chan: ~ch, value: ~v, openSensor: ~op};
    endtask : send
endmodule : aiam_front_model

// ### tb/aiam_monitor_tb_top.sv
// aiam_monitor_tb_top: self-checking bench, reads queued as notes and checked one cycle later
// assumes the front end model owns the sample port and the bench owns the register port
`timescale 1ns/1ns
module aiam_monitor_tb_top
    import aiam_pkg::*;
;
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [BW-1:0] data;
    } aiam_note_t;

    logic          clk = 1'b0;
    logic          nrst = 1'b0;
    aiam_bus_t     bus = '0;
    logic [BW-1:0] busRdata;
    aiam_sample_t  smp;
    logic [NDO-1:0] dout;
    logic [NCH-1:0] hiAlarm;
    logic [NCH-1:0] loAlarm;
    logic [NCH-1:0] burnout;
    logic [NCH-1:0] overRange;
    int            bad_count = 0;
    int            check_count = 0;
    aiam_note_t    notes[$];
    aiam_note_t    cur;
    logic          armed = 1'b0;
    logic [31:0]   seed = 32'd28402;
    logic [DW-1:0] lastV [NCH];
    logic [DW-1:0] mx;
    logic [DW-1:0] mn;
    logic [DW-1:0] v;

    always #2 clk = ~clk;

    aiam_front_model fe (.clk(clk), .smp(smp));
    aiam_monitor uut (.clk(clk), .nrst(nrst), .bus(bus), .busRdata(busRdata), .smp(smp),
        .dout(dout), .hiAlarm(hiAlarm), .loAlarm(loAlarm), .burnout(burnout),
        .overRange(overRange));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    function automatic logic [AW-1:0] ca(input int c, input logic [2:0] f);
        return {CH_SEL, c[2:0], f};
    endfunction : ca

    // floor of the mean over enabled channels, using the last code each one received
    function automatic logic [BW-1:0] avgOf(input logic [NCH-1:0] en);
        int s = 0;
        int n = 0;
        for (int i = 0; i < NCH; i++) begin
            if (en[i]) begin
                s += lastV[i];
                n++;
            end
        end
        return (n == 0) ? '0 : BW'(s / n);
    endfunction : avgOf

    task automatic check(input logic [BW-1:0] seen, input logic [BW-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic complete_run();
        if (bad_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run

    task automatic wr(input logic [AW-1:0] a, input logic [BW-1:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr

    task automatic rdx(input logic [AW-1:0] a, input logic [BW-1:0] e);
        notes.push_back('{addr: a, data: e});
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: xs()};
        @(posedge clk);
        bus.rd <= 1'b0;
    endtask : rdx

    task automatic samp(input int c, input logic [DW-1:0] val, input logic op);
        fe.send(c[CW-1:0], val, op);
        lastV[c] = val;
    endtask : samp

    // read data stands only in the cycle after the strobe, so it is taken at that edge
    always @(posedge clk) begin
        if (armed) begin
            if (notes.size() == 0) begin
                bad_count++;
            end else begin
                cur = notes.pop_front();
                check(busRdata, cur.data);
                if (cur.addr == OFF_ALMSTAT) check({16'h0, loAlarm, hiAlarm}, cur.data);
                if (cur.addr == OFF_FAULT) check({16'h0, overRange, burnout}, cur.data);
                if (cur.addr == OFF_DOUT) check({24'h0, dout}, cur.data);
            end
        end
        armed = bus.rd;
    end

    initial begin
        for (int i = 0; i < NCH; i++) lastV[i] = '0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rdx(ca(0, F_HILIM), 32'h0000ffff);
        rdx(ca(0, F_LOLIM), 32'h0);
        rdx(ca(2, F_MAX), 32'h0);
        rdx(ca(2, F_MIN), 32'h0000ffff);
        rdx(8'h20, 32'h0);
        // ch0: high latching onto output 2, low momentary onto output 5
        wr(ca(0, F_HILIM), 32'h1000);
        wr(ca(0, F_LOLIM), 32'h0100);
        wr(ca(0, F_MODE), 32'h9);
        wr(ca(0, F_MAP), 32'h52);
        rdx(ca(0, F_HILIM), 32'h1000);
        rdx(ca(0, F_MODE), 32'h9);
        rdx(ca(0, F_MAP), 32'h52);
        samp(0, 16'h1000, 1'b0);
        rdx(OFF_ALMSTAT, 32'h0);
        samp(0, 16'h1001, 1'b0);
        rdx(OFF_ALMSTAT, 32'h1);
        rdx(OFF_DOUT, 32'h4);
        samp(0, 16'h00ff, 1'b0);
        rdx(OFF_ALMSTAT, 32'h101);
        rdx(OFF_DOUT, 32'h24);
        samp(0, 16'h0100, 1'b0);
        rdx(OFF_ALMSTAT, 32'h1);
        rdx(OFF_DOUT, 32'h4);
        wr(OFF_CLRLATCH, 32'h1);
        rdx(OFF_ALMSTAT, 32'h0);
        rdx(OFF_DOUT, 32'h0);
        // ch0 switched to high momentary, low disabled
        wr(ca(0, F_MODE), 32'h2);
        samp(0, 16'h1001, 1'b0);
        rdx(OFF_ALMSTAT, 32'h1);
        rdx(OFF_DOUT, 32'h4);
        samp(0, 16'h0800, 1'b0);
        rdx(OFF_ALMSTAT, 32'h0);
        rdx(OFF_DOUT, 32'h0);
        // ch1 left disabled: its condition holds yet nothing moves
        wr(ca(1, F_HILIM), 32'h10);
        wr(ca(1, F_MAP), 32'h3);
        samp(1, 16'h20, 1'b0);
        rdx(OFF_ALMSTAT, 32'h0);
        rdx(OFF_DOUT, 32'h0);
        // ch1: unused high code reads as disabled, low latching onto output 0
        wr(ca(1, F_MODE), 32'h7);
        wr(ca(1, F_LOLIM), 32'h30);
        rdx(ca(1, F_MODE), 32'h4);
        samp(1, 16'h20, 1'b0);
        rdx(OFF_ALMSTAT, 32'h200);
        rdx(OFF_DOUT, 32'h1);
        mx = '0;
        mn = '1;
        for (int k = 0; k < 12; k++) begin
            v = DW'(xs());
            samp(2, v, 1'b0);
            if (v > mx) mx = v;
            if (v < mn) mn = v;
        end
        rdx(ca(2, F_MAX), {16'h0, mx});
        rdx(ca(2, F_MIN), {16'h0, mn});
        rdx(ca(2, F_LAST), {16'h0, v});
        wr(OFF_MMRESET, 32'h4);
        rdx(ca(2, F_MAX), 32'h0);
        rdx(ca(2, F_MIN), 32'h0000ffff);
        wr(OFF_AVGEN, 32'h4);
        rdx(OFF_AVGEN, 32'h4);
        samp(2, 16'h0123, 1'b0);
        rdx(OFF_AVG, 32'h0123);
        wr(OFF_AVGEN, 32'h7);
        samp(2, 16'h0301, 1'b0);
        rdx(OFF_AVG, avgOf(8'h07));
        wr(OFF_BURNSUP, 32'h8);
        wr(OFF_RANGEHI, 32'h8000);
        samp(3, 16'h0010, 1'b1);
        samp(4, 16'h9000, 1'b1);
        rdx(OFF_FAULT, 32'h1008);
        samp(3, 16'h0010, 1'b0);
        rdx(OFF_FAULT, 32'h1000);
        for (int k = 0; k < 8 && notes.size() > 0; k++) @(posedge clk);
        if (notes.size() > 0) bad_count++;
        complete_run();
    end
endmodule : aiam_monitor_tb_top
